// ---- pmi_pkg.sv ----
// Notes on behaviour
// - Mode 00: serial receive data sampled on the internal recovered clock.
// - Mode 01: serial receive data sampled on the external serial receive clock.
// - Each serial transmit bit launched with the rising edge of the transmit clock out.
// - Serial transmit clock out: synthesizer in mode 00, external input in mode 01.
// - Parallel mode: receive byte sampled on rising edges of the parallel receive clock.
// - Parallel mode: transmit clock forwarded out, byte driven on its rising edges.
// - Mode 00, source field 10: synthesizer takes the parallel transmit clock input.
// - Medium alarm level mirrored to status; its change raises an interrupt event.
// - Configuration bit adds the medium alarm to loss-of-signal declaration.
// - Three alarm pins each show an ORed software-selected set of conditions.
// - In frame sync, 8 kHz frame pulse one receive system clock period wide.
// - Receive system clock is serial line clock divided by 8, parallel line clock undivided; stopped during reset.
// - Transmit system clock is serial line clock divided by 8, parallel line clock undivided; stopped during reset.
package pmi_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_MODE_CFG = 8'h00;
    localparam logic [7:0] OFS_ALM_MASK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_MAP_BASE = 8'h14;
    // Field positions and widths
    localparam int LOS_EN_BIT = 0;
    localparam int IRQ_ALM_BIT = 0;
    localparam int IRQ_LOS_BIT = 1;
    localparam int IRQ_W = 2;
    localparam int COND_W = 11;
    localparam int ALM_PINS = 3;
    localparam logic [1:0] TXSRC_PAR = 2'h2;
    // Reset values
    localparam logic [1:0] MODE_CFG_RST = 2'h0;
    localparam logic [COND_W-1:0] MAP_RST = 11'h000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    // Line clock edges per system clock period, system periods per frame
    localparam int DIV_RATIO = 8;
    localparam logic [2:0] BIT_LAST = 3'(DIV_RATIO - 1);
    localparam logic [1:0] HALF_LAST = 2'(DIV_RATIO / 2 - 1);
    localparam real SYS_CLK_MHZ = 19.44;
    localparam real FRAME_KHZ = 8.0;
    localparam logic [11:0] FRAME_LAST = 12'(int'(SYS_CLK_MHZ * 1000.0 / FRAME_KHZ) - 1);
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- pmi_top.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pmi_top
    import pmi_pkg::*;
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    // Mode pins and internal clock sources
    input wire logic [1:0] mode_sel,
    input wire logic recovered_clk_in,
    input wire logic synth_clk_in,
    output logic synth_ref_from_par,
    // Serial medium side
    input wire logic serial_rx_data_pos,
    input wire logic serial_rx_clk_pos,
    input wire logic serial_tx_clk_in_pos,
    output logic serial_tx_data_pos,
    output logic serial_tx_data_neg,
    output logic serial_tx_clk_out_pos,
    output logic serial_tx_clk_out_neg,
    // Parallel medium side
    input wire logic [7:0] par_rx_data,
    input wire logic par_rx_clk,
    input wire logic par_tx_clk_in,
    output logic [7:0] par_tx_data,
    output logic par_tx_clk_out,
    // Framer side
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_byte_take,
    input wire logic frame_sync_in,
    output logic rx_frame_pulse,
    output logic rx_sys_clk_out,
    output logic tx_sys_clk_out,
    // Alarms
    input wire logic medium_alarm_in,
    input wire logic los_detect_in,
    input wire logic [COND_W-3:0] framer_cond_in,
    output logic los_declared,
    output logic [ALM_PINS-1:0] alarm_out_pins
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and clock selection
    logic [1:0] mode_config_reg1;
    logic [0:0] alarm_condition_mask_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set, irq_clr;
    logic [COND_W-1:0] map_reg [ALM_PINS];
    logic [COND_W-1:0] cond_vec;
    logic serial_mode, rx_clk_sel, tx_clk_sel, rx_rise, tx_rise, rx_clk_prev, tx_clk_prev;
    logic [2:0] rx_bit_cnt, tx_bit_cnt;
    logic [7:0] rx_shift, tx_shift, aw_addr;
    logic [11:0] frm_cnt;
    logic [31:0] w_data, rd_next;
    logic [3:0] w_strb;
    logic med_lvl_reg, aw_got, w_got, rd_err_next, wr_err, los_next;
    // Checks below share one clock and reset
    default clocking dflt_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    assign serial_mode = ~mode_sel[1];
    assign rx_clk_sel = mode_sel[1] ? par_rx_clk :
                        mode_sel[0] ? serial_rx_clk_pos : recovered_clk_in;
    assign tx_clk_sel = mode_sel[1] ? par_tx_clk_in :
                        mode_sel[0] ? serial_tx_clk_in_pos : synth_clk_in;
    assign rx_rise = rx_clk_sel & ~rx_clk_prev;
    assign tx_rise = tx_clk_sel & ~tx_clk_prev;

    ////////////////////////////////////////////////////////////////////////
    // Receive path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rx_clk_prev, rx_bit_cnt, rx_shift, rx_byte, rx_byte_valid, rx_sys_clk_out} <= '0;
        end else if (ce) begin
            rx_clk_prev <= rx_clk_sel;
            rx_byte_valid <= 1'b0;
            if (rx_rise && serial_mode) begin
                rx_shift <= {rx_shift[6:0], serial_rx_data_pos};
                rx_bit_cnt <= rx_bit_cnt + 3'h1;
                if (rx_bit_cnt == BIT_LAST) begin
                    rx_byte <= {rx_shift[6:0], serial_rx_data_pos};
                    rx_byte_valid <= 1'b1;
                end
                if (rx_bit_cnt[1:0] == HALF_LAST) begin
                    rx_sys_clk_out <= ~rx_sys_clk_out;
                end
            end else if (rx_rise) begin
                rx_byte <= par_rx_data;
                rx_byte_valid <= 1'b1;
            end
            // parallel line clock already at system rate
            if (!serial_mode) begin
                rx_sys_clk_out <= rx_clk_sel;
            end
        end
    end

    // Frame pulse, one system period every frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {frm_cnt, rx_frame_pulse} <= '0;
        end else if (ce && rx_byte_valid) begin
            frm_cnt <= (frm_cnt == FRAME_LAST) ? 12'h000 : frm_cnt + 12'h001;
            rx_frame_pulse <= frame_sync_in && (frm_cnt == FRAME_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {tx_clk_prev, tx_bit_cnt, tx_shift, tx_byte_take, serial_tx_data_pos} <= '0;
            {serial_tx_clk_out_pos, serial_tx_clk_out_neg, par_tx_data, par_tx_clk_out} <= '0;
            {tx_sys_clk_out, synth_ref_from_par} <= '0;
            serial_tx_data_neg <= 1'b1;
        end else if (ce) begin
            tx_clk_prev <= tx_clk_sel;
            tx_byte_take <= 1'b0;
            // serial clock out follows chosen source
            serial_tx_clk_out_pos <= serial_mode & tx_clk_sel;
            serial_tx_clk_out_neg <= serial_mode & ~tx_clk_sel;
            par_tx_clk_out <= mode_sel[1] & par_tx_clk_in;
            synth_ref_from_par <= (mode_sel == 2'b00) &&
                                  (mode_config_reg1 == TXSRC_PAR);
            if (tx_rise && serial_mode) begin
                serial_tx_data_pos <= tx_shift[7];
                serial_tx_data_neg <= ~tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
                tx_bit_cnt <= tx_bit_cnt + 3'h1;
                if (tx_bit_cnt == BIT_LAST) begin
                    tx_shift <= tx_byte;
                    tx_byte_take <= 1'b1;
                end
                if (tx_bit_cnt[1:0] == HALF_LAST) begin
                    tx_sys_clk_out <= ~tx_sys_clk_out;
                end
            end else if (tx_rise) begin
                par_tx_data <= tx_byte;
                tx_byte_take <= 1'b1;
            end
            if (!serial_mode) begin
                tx_sys_clk_out <= tx_clk_sel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarms and interrupt events
    assign cond_vec = {framer_cond_in, los_declared, med_lvl_reg};
    // medium alarm joins loss of signal
    assign los_next = los_detect_in |
                      (alarm_condition_mask_reg[LOS_EN_BIT] & medium_alarm_in);
    assign irq_set = {los_next & ~los_declared, medium_alarm_in ^ med_lvl_reg};
    assign irq_clr = (aw_got && w_got && !s_axi_bvalid && aw_addr == OFS_IRQ_STAT
                      && w_strb[0]) ? w_data[IRQ_W-1:0] : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {med_lvl_reg, los_declared, irq_stat_reg, irq} <= '0;
        end else if (ce) begin
            // mirror level, set wins over clear
            med_lvl_reg <= medium_alarm_in;
            los_declared <= los_next;
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
        end
    end

    // Alarm pins, one selectable OR per pin
    for (genvar p = 0; p < ALM_PINS; p++) begin : g_alm
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                alarm_out_pins[p] <= 1'b0;
            end else if (ce) begin
                alarm_out_pins[p] <= |(cond_vec & map_reg[p]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side
    // Map is contiguous from zero, so an aligned word past the last map is unmapped
    assign wr_err = aw_addr > OFS_MAP_BASE + 8'h08;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_got, w_got, aw_addr, w_data, w_strb} <= '0;
            {s_axi_awready, s_axi_wready, s_axi_bvalid} <= '0;
            s_axi_bresp <= RESP_OKAY;
            mode_config_reg1 <= MODE_CFG_RST;
            alarm_condition_mask_reg <= 1'b0;
            irq_mask_reg <= IRQ_MASK_RST;
            map_reg <= '{default: MAP_RST};
        end else if (ce) begin
            s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_got && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
                if (w_strb[0]) begin
                    unique case (aw_addr)
                        OFS_MODE_CFG: mode_config_reg1 <= w_data[1:0];
                        OFS_ALM_MASK: alarm_condition_mask_reg <= w_data[0:0];
                        OFS_IRQ_MASK: irq_mask_reg <= w_data[IRQ_W-1:0];
                        default: ;
                    endcase
                end
                for (int i = 0; i < ALM_PINS; i++) begin
                    if (aw_addr == OFS_MAP_BASE + 8'(4 * i)) begin
                        if (w_strb[0]) map_reg[i][7:0] <= w_data[7:0];
                        if (w_strb[1]) map_reg[i][COND_W-1:8] <= w_data[COND_W-1:8];
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side
    always_comb begin
        rd_next = 32'h0000_0000;
        rd_err_next = 1'b0;
        unique case ({s_axi_araddr[7:2], 2'b00})
            OFS_MODE_CFG: rd_next[1:0] = mode_config_reg1;
            OFS_ALM_MASK: rd_next[0] = alarm_condition_mask_reg[0];
            OFS_STATUS: rd_next[4:0] = {frame_sync_in, mode_sel, los_declared, med_lvl_reg};
            OFS_IRQ_STAT: rd_next[IRQ_W-1:0] = irq_stat_reg;
            OFS_IRQ_MASK: rd_next[IRQ_W-1:0] = irq_mask_reg;
            OFS_MAP_BASE: rd_next[COND_W-1:0] = map_reg[0];
            OFS_MAP_BASE + 8'h04: rd_next[COND_W-1:0] = map_reg[1];
            OFS_MAP_BASE + 8'h08: rd_next[COND_W-1:0] = map_reg[2];
            default: rd_err_next = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {s_axi_arready, s_axi_rvalid, s_axi_rdata} <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_next;
                s_axi_rresp <= rd_err_next ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    rx_rec_clk_a: assert property (
        (ce && mode_sel == 2'b00 && recovered_clk_in && !rx_clk_prev)
        |=> rx_bit_cnt == 3'($past(rx_bit_cnt) + 3'h1))
        else $error("recovered clock edge not counted");
    rx_ext_clk_a: assert property (
        (ce && mode_sel == 2'b01 && serial_rx_clk_pos && !rx_clk_prev)
        |=> rx_shift[0] == $past(serial_rx_data_pos))
        else $error("external clock sample lost");
    tx_launch_a: assert property (
        (serial_mode && $changed(serial_tx_data_pos)) |-> $rose(serial_tx_clk_out_pos))
        else $error("serial bit not on clock rise");
    tx_clk_src_a: assert property (
        (ce && mode_sel == 2'b01) |=> serial_tx_clk_out_pos == $past(serial_tx_clk_in_pos))
        else $error("serial clock out not from input");
    par_rx_cap_a: assert property (
        (ce && mode_sel[1] && par_rx_clk && !rx_clk_prev)
        |=> rx_byte == $past(par_rx_data) && rx_byte_valid)
        else $error("parallel byte not captured");
    par_tx_out_a: assert property (
        $changed(par_tx_data) |-> $rose(par_tx_clk_out))
        else $error("parallel byte off clock rise");
    alm_event_a: assert property (
        (ce && medium_alarm_in != med_lvl_reg) |=> irq_stat_reg[IRQ_ALM_BIT])
        else $error("alarm change not flagged");
    los_merge_a: assert property (
        (ce && alarm_condition_mask_reg[0] && medium_alarm_in) |=> los_declared)
        else $error("medium alarm not in LOS");
    frame_pulse_a: assert property (
        rx_frame_pulse |-> frm_cnt == 12'h000)
        else $error("frame pulse off frame count");
    sys_clk_stop_a: assert property (
        $rose(aresetn) |-> !rx_sys_clk_out && !tx_sys_clk_out)
        else $error("system clock ran in reset");
endmodule // pmi_top
`default_nettype wire

// ---- pmi_medium_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmi_medium_model #(
    parameter int HALF = 2
) (
    // Clock, reset, mode strap
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] mode_sel,
    // Line clocks toward the device
    output logic recovered_clk_in,
    output logic synth_clk_in,
    output logic serial_rx_clk_pos,
    output logic serial_tx_clk_in_pos,
    output logic par_rx_clk,
    output logic par_tx_clk_in,
    // Line data toward the device
    output logic serial_rx_data_pos,
    output logic [7:0] par_rx_data
);
    localparam logic [7:0] SER_BYTE = 8'hc5;
    logic [2:0] cnt_reg, bit_reg;
    logic line_clk_reg;
    logic [7:0] par_reg;
    // Line clock, still in reset; data moves on its fall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {cnt_reg, line_clk_reg, bit_reg, par_reg} <= {4'h0, 3'h7, 8'h3c};
        end else if (cnt_reg == 3'(HALF - 1)) begin
            cnt_reg <= 3'h0;
            line_clk_reg <= ~line_clk_reg;
            if (line_clk_reg) begin
                bit_reg <= bit_reg - 3'h1;
                par_reg <= par_reg + 8'h01;
            end
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
    // Only the sources of the strapped mode run, except par_tx_clk_in, which runs in every mode
    assign recovered_clk_in = (mode_sel == 2'h0) & line_clk_reg;
    assign synth_clk_in = recovered_clk_in;
    assign serial_rx_clk_pos = (mode_sel == 2'h1) & line_clk_reg;
    assign serial_tx_clk_in_pos = serial_rx_clk_pos;
    assign par_rx_clk = mode_sel[1] & line_clk_reg;
    assign par_tx_clk_in = line_clk_reg;
    // Unused data lines keep changing
    assign serial_rx_data_pos = mode_sel[1] ? cnt_reg[0] : SER_BYTE[bit_reg];
    assign par_rx_data = mode_sel[1] ? par_reg : ~par_reg;
endmodule // pmi_medium_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb
    import pmi_pkg::*;
;
    logic aclk, aresetn, ce, irq, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, par_rx_data, par_tx_data, rx_byte, tx_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode_sel;
    logic recovered_clk_in, synth_clk_in, synth_ref_from_par, serial_rx_data_pos;
    logic serial_rx_clk_pos, serial_tx_clk_in_pos, serial_tx_data_pos, serial_tx_data_neg;
    logic serial_tx_clk_out_pos, serial_tx_clk_out_neg, par_rx_clk, par_tx_clk_in;
    logic par_tx_clk_out, rx_byte_valid, tx_byte_take, frame_sync_in, rx_frame_pulse;
    logic rx_sys_clk_out, tx_sys_clk_out, medium_alarm_in, los_detect_in, los_declared;
    logic [COND_W-3:0] framer_cond_in;
    logic [ALM_PINS-1:0] alarm_out_pins;
    logic [COND_W-1:0] maps [ALM_PINS];
    int err_total, comparisons;
    pmi_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .mode_sel, .recovered_clk_in,
        .synth_clk_in, .synth_ref_from_par, .serial_rx_data_pos, .serial_rx_clk_pos,
        .serial_tx_clk_in_pos, .serial_tx_data_pos, .serial_tx_data_neg, .serial_tx_clk_out_pos,
        .serial_tx_clk_out_neg, .par_rx_data, .par_rx_clk, .par_tx_clk_in, .par_tx_data,
        .par_tx_clk_out, .rx_byte, .rx_byte_valid, .tx_byte, .tx_byte_take, .frame_sync_in,
        .rx_frame_pulse, .rx_sys_clk_out, .tx_sys_clk_out, .medium_alarm_in, .los_detect_in,
        .framer_cond_in, .los_declared, .alarm_out_pins);
    pmi_medium_model #(.HALF(2)) model (.aclk, .aresetn, .mode_sel, .recovered_clk_in,
        .synth_clk_in, .serial_rx_clk_pos, .serial_tx_clk_in_pos, .par_rx_clk, .par_tx_clk_in,
        .serial_rx_data_pos, .par_rx_data);
    ////////////////////////////////////////////////////////////////////////
    // Common tasks
    task automatic chk(input logic c, input string m);
        comparisons++;
        if (c !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic do_reset(input logic [1:0] m);
        aresetn <= 1'b0;
        mode_sel <= m;
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            chk(i == 0 || !(rx_sys_clk_out | tx_sys_clk_out), "clk in reset");
        end
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 64);
        s_axi_bready <= 1'b0;
        chk(s_axi_bvalid === 1'b1 && s_axi_bresp === er, "write resp");
        @(posedge aclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 64);
        s_axi_rready <= 1'b0;
        chk(s_axi_rvalid === 1'b1 && s_axi_rresp === er && s_axi_rdata === e, "read word");
        @(posedge aclk);
    endtask
    task automatic t_sys(input int e);
        int kr = 0, kt = 0;
        logic pr = rx_sys_clk_out, pt = tx_sys_clk_out;
        repeat (320) begin
            @(posedge aclk);
            kr += int'(rx_sys_clk_out === 1'b1 && pr === 1'b0);
            kt += int'(tx_sys_clk_out === 1'b1 && pt === 1'b0);
            {pr, pt} = {rx_sys_clk_out, tx_sys_clk_out};
        end
        chk(kr >= e - 1 && kr <= e + 1, "rx sys rate");
        chk(kt >= e - 1 && kt <= e + 1, "tx sys rate");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        rd_chk(OFS_MODE_CFG, 32'(MODE_CFG_RST), RESP_OKAY);
        rd_chk(OFS_IRQ_MASK, 32'(IRQ_MASK_RST), RESP_OKAY);
        for (int p = 0; p < ALM_PINS; p++) rd_chk(OFS_MAP_BASE + 8'(4 * p), 32'(MAP_RST), RESP_OKAY);
        rd_chk(8'h20, 32'h0, RESP_SLVERR);
        axi_wr(8'h20, 32'hffffffff, RESP_SLVERR);
        axi_wr(OFS_MODE_CFG, 32'(TXSRC_PAR), RESP_OKAY);
        cyc(2);
        chk(synth_ref_from_par === 1'b1, "synth ref par");
        axi_wr(OFS_MODE_CFG, 32'h0, RESP_OKAY);
        cyc(2);
        chk(synth_ref_from_par === 1'b0, "synth ref own");
        $display("test regs done");
    endtask
    task automatic t_alarm;
        axi_wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
        medium_alarm_in <= 1'b1;
        cyc(4);
        chk(irq === 1'b1, "irq on alarm");
        rd_chk(OFS_STATUS, 32'h1, RESP_OKAY);
        rd_chk(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        axi_wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        cyc(3);
        chk(irq === 1'b0, "irq cleared");
        axi_wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        medium_alarm_in <= 1'b0;
        cyc(4);
        chk(irq === 1'b0, "irq masked");
        rd_chk(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        axi_wr(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
        axi_wr(OFS_ALM_MASK, 32'h1, RESP_OKAY);
        medium_alarm_in <= 1'b1;
        cyc(4);
        chk(los_declared === 1'b1, "los from alarm");
        rd_chk(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
        axi_wr(OFS_ALM_MASK, 32'h0, RESP_OKAY);
        cyc(4);
        chk(los_declared === 1'b0, "los alarm off");
        medium_alarm_in <= 1'b0;
        $display("test alarm done");
    endtask
    task automatic t_map;
        logic [ALM_PINS-1:0] e;
        for (int p = 0; p < ALM_PINS; p++) axi_wr(OFS_MAP_BASE + 8'(4 * p), 32'(maps[p]), RESP_OKAY);
        for (int j = 0; j < COND_W; j++) begin
            medium_alarm_in <= (j == 0);
            los_detect_in <= (j == 1);
            framer_cond_in <= (COND_W - 2)'(j >= 2) << (j - 2);
            cyc(4);
            for (int p = 0; p < ALM_PINS; p++) e[p] = maps[p][j];
            chk(alarm_out_pins === e, "alarm pin map");
        end
        framer_cond_in <= '0;
        $display("test map done");
    endtask
    task automatic t_ser(input logic [1:0] m);
        int n, k = 0, hits = 0;
        logic [7:0] sh;
        logic pc, pd;
        do_reset(m);
        for (n = 0; k < 3 && n < 400; n++) begin
            @(posedge aclk);
            if (rx_byte_valid === 1'b1) begin
                chk(rx_byte === 8'hc5, "serial rx byte");
                k++;
            end
        end
        chk(k == 3, "serial rx count");
        k = 0;
        {pc, pd} = {serial_tx_clk_out_pos, serial_tx_data_pos};
        for (n = 0; k < 24 && n < 400; n++) begin
            @(posedge aclk);
            if (serial_tx_clk_out_pos === 1'b1 && pc === 1'b0) begin
                sh = {sh[6:0], serial_tx_data_pos};
                k++;
                if (k >= 8 && sh === 8'he8) hits++;
            end else chk(serial_tx_data_pos === pd, "tx data off edge");
            chk({serial_tx_data_neg, serial_tx_clk_out_neg} ===
                ~{serial_tx_data_pos, serial_tx_clk_out_pos}, "tx complement");
            {pc, pd} = {serial_tx_clk_out_pos, serial_tx_data_pos};
        end
        chk(hits >= 2, "serial tx byte");
        t_sys(10);
        $display("test serial done");
    endtask
    task automatic t_par;
        int n, k = 0, r = 0;
        logic pc;
        do_reset(2'h2);
        pc = par_tx_clk_out;
        for (n = 0; k < 6 && n < 200; n++) begin
            @(posedge aclk);
            if (rx_byte_valid === 1'b1) begin
                chk(rx_byte === 8'h3c + 8'(k), "par rx byte");
                k++;
            end
            if (par_tx_clk_out === 1'b1 && pc === 1'b0) begin
                r++;
                if (r > 2) chk(par_tx_data === tx_byte, "par tx");
            end
            chk(serial_tx_clk_out_pos === 1'b0, "serial clk idle");
            pc = par_tx_clk_out;
        end
        chk(k == 6 && r >= 4, "par counts");
        t_sys(80);
        $display("test parallel done");
    endtask
    task automatic t_frame;
        int n, w = 0;
        repeat (10000) begin
            @(posedge aclk);
            w += int'(rx_frame_pulse !== 1'b0);
        end
        chk(w == 0, "pulse without sync");
        frame_sync_in <= 1'b1;
        for (n = 0; rx_frame_pulse !== 1'b1 && n < 10000; n++) @(posedge aclk);
        for (w = 0; rx_frame_pulse === 1'b1 && w < 20; w++) @(posedge aclk);
        chk(w == 4, "pulse width");
        for (n = 0; rx_frame_pulse !== 1'b1 && n < 10000; n++) @(posedge aclk);
        chk(n >= 9715 && n <= 9717, "frame period");
        frame_sync_in <= 1'b0;
        $display("test frame done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Verdict and run control
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Clock at 200 MHz
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Hang guard
    initial begin
        #300000;
        err_total++;
        $display("[FAIL] %0t watchdog", $time);
        report_and_stop;
    end
    // Main sequence
    initial begin
        {err_total, comparisons} = '0;
        {ce, aresetn, mode_sel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 51'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {frame_sync_in, medium_alarm_in, los_detect_in, framer_cond_in} = '0;
        s_axi_wstrb = 4'hf;
        tx_byte = 8'he8;
        maps = '{11'h002, 11'h004, 11'h401};
        do_reset(2'h0);
        t_regs;
        t_alarm;
        t_map;
        t_ser(2'h0);
        t_ser(2'h1);
        t_par;
        t_frame;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
